// ===== dsp_pkg.sv
`default_nettype none
package dsp_pkg;

  // ****************************************
  // widths and lane layout
  // ****************************************
  localparam int OPW = 18;          // one multiplier operand
  localparam int HALFW = 9;         // operand of a split 9x9 multiplier
  localparam int PRODW = 36;        // product of one 18x18 multiplier
  localparam int HPRODW = 18;       // product of one 9x9 multiplier
  localparam int LANEW = 38;        // adder lane, room for sum of four products
  localparam int WIDEW = 72;        // full 36x36 product
  localparam int NMUL = 4;          // multipliers in one block
  localparam int NLANE = 4;         // adder result lanes
  localparam int PART_SHIFT = 18;   // weight of cross partial products
  localparam int HIGH_SHIFT = 36;   // weight of the high partial product
  localparam int PIPE_LAT = 3;      // edges from operand to result

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [WIDEW-1:0] WIDE_RST = 72'h0;
  localparam logic [LANEW-1:0] LANE_RST = 38'h0;

  // ****************************************
  // modes and carriers
  // ****************************************
  typedef enum logic [1:0] {
    MODE_WIDE,     // one 36x36 multiply
    MODE_ADD2,     // pairs of products added or subtracted
    MODE_ADD4      // four products summed
  } mode_e;

  // control bundle travelling with the data
  typedef struct packed {
    mode_e mode;
    logic nine;       // split each multiplier into two 9x9
    logic a_signed;
    logic b_signed;
    logic sub0;       // first adder subtracts
    logic sub1;       // second adder subtracts
    logic shift_en;   // chain operand a through the input registers
  } ctrl_s;

  localparam int CTRLW = $bits(ctrl_s);
  localparam ctrl_s CTRL_RST = '{MODE_WIDE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  // operand bundle for the four multipliers
  typedef struct packed {
    logic [NMUL-1:0][OPW-1:0] a;
    logic [NMUL-1:0][OPW-1:0] b;
  } operands_s;

  // result bundle
  typedef struct packed {
    logic [WIDEW-1:0] wide;
    logic [NLANE-1:0][LANEW-1:0] lane;
  } res_s;

endpackage
`default_nettype wire

// ===== mul18_slice.sv
`timescale 1ns/1ps
`default_nettype none
module mul18_slice
  import dsp_pkg::*;
(
  input wire logic [OPW-1:0] a_in,         // operand a
  input wire logic [OPW-1:0] b_in,         // operand b
  input wire logic a_signed_in,            // a is two's complement
  input wire logic b_signed_in,            // b is two's complement
  input wire logic split_in,               // two 9x9 products instead of one 18x18
  output logic [PRODW-1:0] prod_out        // product, or {high, low} half products
);

  // ****************************************
  // one 18x18 or two 9x9 multipliers
  // ****************************************
  logic signed [OPW:0] a_x;                // sign or zero extended operands
  logic signed [OPW:0] b_x;
  logic signed [2*OPW+1:0] full_p;
  logic signed [HALFW:0] al_x;
  logic signed [HALFW:0] bl_x;
  logic signed [HALFW:0] ah_x;
  logic signed [HALFW:0] bh_x;
  logic signed [2*HALFW+1:0] lo_p;
  logic signed [2*HALFW+1:0] hi_p;

  // the extra bit lets one signed multiplier serve all sign mixes
  always_comb begin
    a_x = {a_signed_in & a_in[OPW-1], a_in};
    b_x = {b_signed_in & b_in[OPW-1], b_in};
    al_x = {a_signed_in & a_in[HALFW-1], a_in[HALFW-1:0]};
    bl_x = {b_signed_in & b_in[HALFW-1], b_in[HALFW-1:0]};
    ah_x = {a_signed_in & a_in[OPW-1], a_in[OPW-1:HALFW]};
    bh_x = {b_signed_in & b_in[OPW-1], b_in[OPW-1:HALFW]};
    // widen before multiplying so no product bit is padded in silently
    full_p = (2*OPW+2)'(a_x) * (2*OPW+2)'(b_x);
    lo_p = (2*HALFW+2)'(al_x) * (2*HALFW+2)'(bl_x);
    hi_p = (2*HALFW+2)'(ah_x) * (2*HALFW+2)'(bh_x);
    // top bits of the extended products carry only sign copies
    if (split_in) begin
      prod_out = {hi_p[HPRODW-1:0], lo_p[HPRODW-1:0]};
    end else begin
      prod_out = full_p[PRODW-1:0];
    end
  end

endmodule
`default_nettype wire

// ===== dsp_block.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - input regs, multipliers, then pipeline register
// - each control combinational or registered once
// - four 18x18 products shifted into 36x36
// - operand chaining disabled in wide mode
// - product register pipelines the wide multiply
// - two-adder mode: paired sums or differences
// - complex: real subtracts, imaginary adds
// - 9-bit: two complex products at once
// - second adder sums both first adders
// - four-adder: one 18-bit or two 9-bit sums
module dsp_block
  import dsp_pkg::*;
(
  input wire logic core_clk_in,              // block clock
  input wire logic resetn_in,                // asynchronous reset, active low
  input wire operands_s operand_in,          // operands from the fabric
  input wire logic valid_in,                 // operands present this cycle
  input wire ctrl_s ctrl_in,                 // controls from the fabric
  input wire logic [CTRLW-1:0] ctrl_regsel_in, // per control bit: 1 registered
  output res_s result_out,                   // wide product and adder lanes
  output logic valid_out                     // result present this cycle
);

  // ****************************************
  // helpers
  // ****************************************
  // sign extend one 18x18 product into an adder lane
  function automatic logic [LANEW-1:0] ext36(input logic [PRODW-1:0] p, input logic s);
    return {{(LANEW-PRODW){s & p[PRODW-1]}}, p};
  endfunction

  // sign extend one 9x9 product into an adder lane
  function automatic logic [LANEW-1:0] ext18(input logic [HPRODW-1:0] p, input logic s);
    return {{(LANEW-HPRODW){s & p[HPRODW-1]}}, p};
  endfunction

  // first stage adder or subtractor
  function automatic logic [LANEW-1:0] addsub(input logic [LANEW-1:0] x,
                                              input logic [LANEW-1:0] y, input logic sub);
    return sub ? (x - y) : (x + y);
  endfunction

  // sign extend a partial product to the wide width
  function automatic logic [WIDEW-1:0] ext72(input logic [PRODW-1:0] p, input logic s);
    return {{(WIDEW-PRODW){s & p[PRODW-1]}}, p};
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ctrl_s ctrl_q;                 // registered copy of the fabric controls
    operands_s opnd;               // input registers
    ctrl_s ctrl1;                  // controls aligned with input registers
    logic v1;
    logic [NMUL-1:0][PRODW-1:0] prod; // product / pipeline registers
    ctrl_s ctrl2;                  // controls aligned with products
    logic v2;
    res_s res;                     // output registers
    logic v3;
  } state_s;

  state_s st_q;
  state_s st_d;
  ctrl_s eff_ctrl;                 // controls after the per-bit register choice
  logic shift_ok;                  // chaining granted
  logic [NMUL-1:0][PRODW-1:0] prod_w; // multiplier outputs
  logic psgn;                      // products at adder stage are signed
  logic [LANEW-1:0] s0_w;          // first adder, full products
  logic [LANEW-1:0] s1_w;          // second adder, full products
  logic [NLANE-1:0][LANEW-1:0] h_w; // half product adders: lo0, hi0, lo1, hi1

  // ****************************************
  // control selection
  // ****************************************
  // picking per bit lets a slow control meet data one stage later
  always_comb begin
    eff_ctrl = ctrl_s'((ctrl_regsel_in & st_q.ctrl_q) | (~ctrl_regsel_in & ctrl_in));
    shift_ok = eff_ctrl.shift_en && (eff_ctrl.mode != MODE_WIDE);
  end

  // ****************************************
  // multipliers
  // ****************************************
  // in wide mode multiplier k takes a half k[0] and b half k[1]
  for (genvar k = 0; k < NMUL; k++) begin : g_mul
    localparam int AI = (k % 2);
    localparam int BI = (k / 2);
    logic wide_m;
    assign wide_m = (st_q.ctrl1.mode == MODE_WIDE);
    mul18_slice u_mul (
      .a_in(wide_m ? st_q.opnd.a[AI] : st_q.opnd.a[k]),
      .b_in(wide_m ? st_q.opnd.b[BI] : st_q.opnd.b[k]),
      .a_signed_in(st_q.ctrl1.a_signed & (~wide_m | (AI == 1))),  // low halves unsigned
      .b_signed_in(st_q.ctrl1.b_signed & (~wide_m | (BI == 1))),
      .split_in(st_q.ctrl1.nine & ~wide_m),
      .prod_out(prod_w[k])
    );
  end

  // ****************************************
  // first stage adders
  // ****************************************
  always_comb begin
    psgn = st_q.ctrl2.a_signed | st_q.ctrl2.b_signed;
    s0_w = addsub(ext36(st_q.prod[0], psgn), ext36(st_q.prod[1], psgn), st_q.ctrl2.sub0);
    s1_w = addsub(ext36(st_q.prod[2], psgn), ext36(st_q.prod[3], psgn), st_q.ctrl2.sub1);
    // four units for two independent 9-bit complex products
    h_w[0] = addsub(ext18(st_q.prod[0][HPRODW-1:0], psgn),
                    ext18(st_q.prod[1][HPRODW-1:0], psgn), st_q.ctrl2.sub0);
    h_w[1] = addsub(ext18(st_q.prod[0][PRODW-1:HPRODW], psgn),
                    ext18(st_q.prod[1][PRODW-1:HPRODW], psgn), st_q.ctrl2.sub0);
    h_w[2] = addsub(ext18(st_q.prod[2][HPRODW-1:0], psgn),
                    ext18(st_q.prod[3][HPRODW-1:0], psgn), st_q.ctrl2.sub1);
    h_w[3] = addsub(ext18(st_q.prod[2][PRODW-1:HPRODW], psgn),
                    ext18(st_q.prod[3][PRODW-1:HPRODW], psgn), st_q.ctrl2.sub1);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.ctrl_q = ctrl_in;
    // input registers, optional chaining of operand a
    st_d.opnd.b = operand_in.b;
    for (int k = 0; k < NMUL; k++) begin
      if (shift_ok && k > 0) begin
        st_d.opnd.a[k] = st_q.opnd.a[k-1];
      end else begin
        st_d.opnd.a[k] = operand_in.a[k];
      end
    end
    st_d.ctrl1 = eff_ctrl;
    st_d.v1 = valid_in;
    // product register, also the mid stage of the wide multiply
    st_d.prod = prod_w;
    st_d.ctrl2 = st_q.ctrl1;
    st_d.v2 = st_q.v1;
    // adder and output stage
    st_d.res.wide = WIDE_RST;
    for (int l = 0; l < NLANE; l++) begin
      st_d.res.lane[l] = LANE_RST;
    end
    case (st_q.ctrl2.mode)
      MODE_WIDE: begin
        // partial products weighted by shifting, summed without loss
        st_d.res.wide = ext72(st_q.prod[0], 1'b0)
          + (ext72(st_q.prod[1], st_q.ctrl2.a_signed) << PART_SHIFT)
          + (ext72(st_q.prod[2], st_q.ctrl2.b_signed) << PART_SHIFT)
          + (ext72(st_q.prod[3], psgn) << HIGH_SHIFT);
      end
      MODE_ADD2: begin
        if (st_q.ctrl2.nine) begin
          st_d.res.lane = h_w;
        end else begin
          st_d.res.lane[0] = s0_w;
          st_d.res.lane[1] = s1_w;
        end
      end
      MODE_ADD4: begin
        if (st_q.ctrl2.nine) begin
          st_d.res.lane[0] = h_w[0] + h_w[2];
          st_d.res.lane[1] = h_w[1] + h_w[3];
        end else begin
          st_d.res.lane[0] = s0_w + s1_w;
        end
      end
      default: begin
        st_d.res.wide = WIDE_RST;                      // unused code gives zero
      end
    endcase
    st_d.v3 = st_q.v2;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '0;
      st_q.ctrl_q <= CTRL_RST;
      st_q.ctrl1 <= CTRL_RST;
      st_q.ctrl2 <= CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign result_out = st_q.res;
  assign valid_out = st_q.v3;

  // ****************************************
  // checks
  // ****************************************
  // independent 36x36 reference from the input registers
  logic signed [2*OPW:0] ref_a;
  logic signed [2*OPW:0] ref_b;
  logic signed [2*(2*OPW+1)-1:0] ref_p;
  assign ref_a = {st_q.ctrl1.a_signed & st_q.opnd.a[1][OPW-1], st_q.opnd.a[1], st_q.opnd.a[0]};
  assign ref_b = {st_q.ctrl1.b_signed & st_q.opnd.b[1][OPW-1], st_q.opnd.b[1], st_q.opnd.b[0]};
  assign ref_p = (2*(2*OPW+1))'(ref_a) * (2*(2*OPW+1))'(ref_b);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  pipe_latency_a: assert property (valid_in |-> ##3 valid_out)
    else $error("result valid not three edges after operands");
  ctrl_regsel_a: assert property ($past(resetn_in) && (&ctrl_regsel_in)
    |-> eff_ctrl == $past(ctrl_in))
    else $error("registered controls not delayed by one stage");
  wide_result_a: assert property (st_q.v1 && st_q.ctrl1.mode == MODE_WIDE
    |-> ##2 st_q.res.wide == $past(ref_p[WIDEW-1:0], 2))
    else $error("wide product mismatch");
  chain_off_a: assert property (eff_ctrl.mode == MODE_WIDE
    |=> st_q.opnd.a[1] == $past(operand_in.a[1]))
    else $error("operand chaining active in wide mode");
  wide_stage_a: assert property (st_q.ctrl1.mode == MODE_WIDE
    |=> st_q.prod == $past(prod_w)
        && st_q.prod[0] == $past({{OPW{1'b0}}, st_q.opnd.a[0]} * {{OPW{1'b0}}, st_q.opnd.b[0]}))
    else $error("wide partial products not held in product register");
  add2_lane_a: assert property (st_q.ctrl2.mode == MODE_ADD2 && !st_q.ctrl2.nine
    |=> $signed(st_q.res.lane[1]) == $past($signed(ext36(st_q.prod[2], psgn))
        + (st_q.ctrl2.sub1 ? -$signed(ext36(st_q.prod[3], psgn))
                           : $signed(ext36(st_q.prod[3], psgn)))))
    else $error("two-multiplier lane wrong");
  add2_nine_a: assert property (st_q.ctrl2.mode == MODE_ADD2 && st_q.ctrl2.nine
    |=> st_q.res.lane[3]
        + ($past(st_q.ctrl2.sub1) ? $past(ext18(st_q.prod[3][35:18], psgn)) : '0)
        == $past(ext18(st_q.prod[2][35:18], psgn))
        + ($past(st_q.ctrl2.sub1) ? '0 : $past(ext18(st_q.prod[3][35:18], psgn))))
    else $error("second 9-bit complex lane wrong");
  add4_sum_a: assert property (st_q.ctrl2.mode == MODE_ADD4 && !st_q.ctrl2.nine
    |=> st_q.res.lane[0] == $past(s0_w + s1_w) && st_q.res.lane[1] == LANE_RST)
    else $error("four-multiplier sum wrong");
  add4_nine_a: assert property (st_q.ctrl2.mode == MODE_ADD4 && st_q.ctrl2.nine
    |=> st_q.res.lane[1] == $past(h_w[1] + h_w[3]) && st_q.res.wide == WIDE_RST)
    else $error("second 9-bit four-product sum wrong");

endmodule
`default_nettype wire

// ===== fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// fabric side: operands and controls toward the block
// ****************************************
module fabric_model
  import dsp_pkg::*;
(
  input wire logic core_clk_in,              // block clock
  input wire operands_s ops_in,              // operands staged by the bench
  input wire ctrl_s ctrl_in,                 // controls staged by the bench
  input wire logic valid_in,                 // staged operand valid
  input wire logic [CTRLW-1:0] regsel_in,    // staged control register select
  output var operands_s operand_out,         // operands toward the block
  output var ctrl_s ctrl_out,                // controls toward the block
  output var logic valid_out,                // operand valid toward the block
  output var logic [CTRLW-1:0] regsel_out    // register select toward the block
);
  // defined values from time zero, then drive just after each rising edge
  // one process owns the outputs, like fabric registers would
  initial begin
    operand_out = '0;
    ctrl_out = CTRL_RST;
    valid_out = 1'b0;
    regsel_out = '0;
    forever begin
      @(posedge core_clk_in);
      #1;
      // one nine bit serves all four multipliers: equal widths per tree
      ctrl_out = ctrl_in;
      regsel_out = regsel_in;
      valid_out = valid_in;
      if (valid_in) begin
        operand_out = ops_in;
      end else begin
        // stale operands are not held: the block must not lean on them
        operand_out = ~operand_out;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_dsp_multiply_add_block.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_multiply_add_block
  import dsp_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  typedef struct { res_s r; int due; } expect_s;
  logic core_clk_in = 1'b0;       // block clock
  logic resetn_in = 1'b0;         // reset, active low
  operands_s st_ops = '0;         // staged operands
  ctrl_s st_ctrl = CTRL_RST;      // staged controls
  logic st_valid = 1'b0;          // staged valid
  logic [CTRLW-1:0] st_regsel = '0; // staged register select
  operands_s op;                  // model to block
  ctrl_s ctrl;
  logic valid;
  logic [CTRLW-1:0] regsel;
  res_s res;                      // block results
  logic vout;
  expect_s q[$];                  // expected results in order
  int cyc = 0;
  int num_errors = 0;
  int checks_done = 0;

  always #5 core_clk_in = ~core_clk_in;

  fabric_model i_fabric (.core_clk_in(core_clk_in), .ops_in(st_ops), .ctrl_in(st_ctrl),
    .valid_in(st_valid), .regsel_in(st_regsel), .operand_out(op), .ctrl_out(ctrl),
    .valid_out(valid), .regsel_out(regsel));
  dsp_block i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .operand_in(op),
    .valid_in(valid), .ctrl_in(ctrl), .ctrl_regsel_in(regsel), .result_out(res),
    .valid_out(vout));

  // ****************************************
  // reference arithmetic
  // ****************************************
  function automatic logic [LANEW-1:0] mul(input logic [OPW-1:0] x, input logic [OPW-1:0] y,
                                           input logic half, input ctrl_s c);
    logic [LANEW-1:0] ex, ey;
    ex = half ? LANEW'(x[HALFW-1:0]) : LANEW'(x);
    ey = half ? LANEW'(y[HALFW-1:0]) : LANEW'(y);
    if (c.a_signed) ex = half ? LANEW'($signed(x[HALFW-1:0])) : LANEW'($signed(x));
    if (c.b_signed) ey = half ? LANEW'($signed(y[HALFW-1:0])) : LANEW'($signed(y));
    return ex * ey;
  endfunction

  function automatic logic [LANEW-1:0] addsub(input logic [LANEW-1:0] x,
                                              input logic [LANEW-1:0] y, input logic s);
    return s ? x - y : x + y;
  endfunction

  // expected result bundle for one operand set under effective controls
  function automatic res_s model_res(input operands_s o, input ctrl_s c);
    res_s r;
    logic [WIDEW-1:0] ea, eb;
    logic [NMUL-1:0][LANEW-1:0] lo, hi;
    r = '0;
    for (int k = 0; k < NMUL; k++) begin
      lo[k] = mul(o.a[k], o.b[k], c.nine, c);
      hi[k] = mul(OPW'(o.a[k][OPW-1:HALFW]), OPW'(o.b[k][OPW-1:HALFW]), 1'b1, c);
    end
    ea = c.a_signed ? WIDEW'($signed({o.a[1], o.a[0]})) : WIDEW'({o.a[1], o.a[0]});
    eb = c.b_signed ? WIDEW'($signed({o.b[1], o.b[0]})) : WIDEW'({o.b[1], o.b[0]});
    case (c.mode)
      MODE_WIDE: r.wide = ea * eb;
      MODE_ADD2: begin
        r.lane[0] = addsub(lo[0], lo[1], c.sub0);
        r.lane[1] = c.nine ? addsub(hi[0], hi[1], c.sub0) : addsub(lo[2], lo[3], c.sub1);
        if (c.nine) begin
          r.lane[2] = addsub(lo[2], lo[3], c.sub1);
          r.lane[3] = addsub(hi[2], hi[3], c.sub1);
        end
      end
      MODE_ADD4: begin
        r.lane[0] = addsub(lo[0], lo[1], c.sub0) + addsub(lo[2], lo[3], c.sub1);
        if (c.nine) r.lane[1] = addsub(hi[0], hi[1], c.sub0) + addsub(hi[2], hi[3], c.sub1);
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // ****************************************
  // stimulus tasks
  // ****************************************
  function automatic ctrl_s mkc(input mode_e m, input logic [5:0] f);
    // f: nine, a_signed, b_signed, sub0, sub1, shift_en
    return ctrl_s'({m, f});
  endfunction

  // stage one cycle of fabric traffic; registered control bits use last cycle's value
  task automatic drive(input logic [71:0] a, input logic [71:0] b, input ctrl_s c,
                       input logic v);
    ctrl_s eff;
    @(posedge core_clk_in);
    eff = ctrl_s'((st_regsel & st_ctrl) | (~st_regsel & c));
    if (v) q.push_back('{model_res(operands_s'({a, b}), eff), cyc + 1 + PIPE_LAT});
    st_ops = operands_s'({a, b});
    st_ctrl = c;
    st_valid = v;
  endtask

  // idle until every expected result has come back, then report
  task automatic finish_scenario(input string name);
    repeat (PIPE_LAT + 2) drive(72'h0, 72'h0, st_ctrl, 1'b0);
    checks_done++;
    if (q.size() != 0) begin
      $display("mismatch at %0t: pending %h expected %h", $time, q.size(), 0);
      num_errors++;
      q.delete();
    end
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask

  // ****************************************
  // result monitor
  // ****************************************
  always @(posedge core_clk_in) cyc <= cyc + 1;

  always @(negedge core_clk_in) begin
    if (resetn_in === 1'b1 && q.size() > 0 && q[0].due == cyc) begin
      checks_done++;
      if ({vout, res} !== {1'b1, q[0].r}) begin
        $display("mismatch at %0t: got %h expected %h", $time, {vout, res}, {1'b1, q[0].r});
        num_errors++;
      end
      void'(q.pop_front());
    end else if (resetn_in === 1'b1 && vout !== 1'b0) begin
      $display("mismatch at %0t: got %h expected %h", $time, vout, 1'b0);
      num_errors++;
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_wide();
    drive(72'h5A5A5A5A5_800000000, 72'hA5A5A5A5A_800000000, mkc(MODE_WIDE, 6'h18), 1);
    drive(72'h123456789_FFFFFFFFF, 72'h987654321_FFFFFFFFF, mkc(MODE_WIDE, 6'h01), 1);
    drive(72'h0_123456789, 72'h0_FEDCBA987, mkc(MODE_WIDE, 6'h10), 1);
    finish_scenario("wide");
  endtask

  task automatic t_add2();
    drive({18'h20000, 18'h1FFFF, 18'h20000, 18'h1FFFF},
          {18'h1FFFF, 18'h20000, 18'h20000, 18'h1FFFF}, mkc(MODE_ADD2, 6'h1C), 1);
    drive({18'h3FFFF, 18'h3FFFF, 18'h00001, 18'h3FFFF},
          {18'h3FFFF, 18'h3FFFF, 18'h00002, 18'h3FFFF}, mkc(MODE_ADD2, 6'h02), 1);
    drive({18'h1FF00, 18'h0FF01, 18'h20100, 18'h0FF01},
          {18'h0FF01, 18'h20100, 18'h1FF00, 18'h1FF00}, mkc(MODE_ADD2, 6'h3C), 1);
    finish_scenario("two_adder");
  endtask

  task automatic t_add4();
    drive({18'h1FFFF, 18'h20000, 18'h1FFFF, 18'h20000},
          {18'h1FFFF, 18'h20000, 18'h20000, 18'h1FFFF}, mkc(MODE_ADD4, 6'h18), 1);
    drive({18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF},
          {18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF}, mkc(MODE_ADD4, 6'h20), 1);
    drive({18'h20100, 18'h0FF01, 18'h1FF00, 18'h2017F},
          {18'h1FF00, 18'h20100, 18'h0FF01, 18'h1FF00}, mkc(MODE_ADD4, 6'h3A), 1);
    finish_scenario("four_adder");
  endtask

  // chaining outside wide mode, then the spare mode code
  task automatic t_chain();
    drive({18'h00004, 18'h00003, 18'h00002, 18'h00001},
          {18'h00007, 18'h00006, 18'h00005, 18'h00004}, mkc(MODE_ADD2, 6'h00), 1);
    drive({18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h00005},
          {18'h00007, 18'h00006, 18'h00005, 18'h00004}, mkc(MODE_ADD4, 6'h01), 1);
    // registers 3..1 take the old registers 2..0, register 0 the new word
    q[q.size()-1].r = model_res(operands_s'({18'h00003, 18'h00002, 18'h00001, 18'h00005,
                                             18'h00007, 18'h00006, 18'h00005, 18'h00004}),
                                mkc(MODE_ADD4, 6'h01));
    drive({18'h00009, 18'h00008, 18'h00007, 18'h00006},
          {18'h00001, 18'h00002, 18'h00003, 18'h00004}, ctrl_s'(8'hC0), 1);
    finish_scenario("chain_and_spare_code");
  endtask

  task automatic t_regctl();
    st_regsel = '1;
    drive(72'h0, 72'h0, mkc(MODE_ADD4, 6'h38), 0);
    drive({18'h00003, 18'h00005, 18'h3FFFF, 18'h00007},
          {18'h00011, 18'h3FFF0, 18'h00002, 18'h00009}, mkc(MODE_WIDE, 6'h00), 1);
    drive({18'h00003, 18'h00005, 18'h3FFFF, 18'h00007},
          {18'h00011, 18'h3FFF0, 18'h00002, 18'h00009}, mkc(MODE_ADD2, 6'h1C), 1);
    finish_scenario("registered_all");
    st_regsel = 8'h04;
    drive(72'h0, 72'h0, mkc(MODE_ADD2, 6'h18), 0);
    drive({18'h00010, 18'h00020, 18'h00030, 18'h00040},
          {18'h00005, 18'h00006, 18'h00007, 18'h00008}, mkc(MODE_ADD2, 6'h1C), 1);
    finish_scenario("registered_sub");
    st_regsel = '0;
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge core_clk_in) begin
    if (cyc == 1000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk_in);
    #1 resetn_in = 1'b1;
    drive(72'h0, 72'h0, CTRL_RST, 0);
    t_wide();
    t_add2();
    t_add4();
    t_chain();
    t_regctl();
    finish_test();
  end
endmodule
`default_nettype wire
